// >>> rccr_defs.vh
// Constants for the radio configuration command register block
// What this block does
// - Written one enables function, zero disables it, except bit 0
// - Power-on defaults 8008h 8208h A680h C623h
// - Data register enable routes tx bits internally
// - FIFO off puts data and clock on pins
// - Band select and crystal load trim fields
// - Bit 7 enables whole receive chain
// - Bit 6 enables receive baseband alone
// - Transmit enable powers synth, osc, amplifier
// - Synth bit runs synth and osc, osc bit runs osc alone
// - Oscillator bit keeps crystal running always
// - Bit 2 battery detector, bit 1 wake timer
// - Bit 0 set disables host clock output
// - Accept channel word 96 to 3903 only
// - Centre frequency from band constants C1 C2
// - Bit rate from divider and prescaler
// - Sample on rising clock, select high resets
// - Ignore commands during power-on timeout
`ifndef RCCR_DEFS_VH
`define RCCR_DEFS_VH
// Reset values
`define RCCR_CFG_RST 16'h8008
`define RCCR_PWR_RST 16'h8208
`define RCCR_FRQ_RST 16'hA680
`define RCCR_RATE_RST 16'hC623
// Command codes: value and mask on the upper bits
`define RCCR_CFG_MASK 16'hFF00
`define RCCR_CFG_CODE 16'h8000
`define RCCR_PWR_MASK 16'hFF00
`define RCCR_PWR_CODE 16'h8200
`define RCCR_FRQ_MASK 16'hF000
`define RCCR_FRQ_CODE 16'hA000
`define RCCR_RATE_MASK 16'hFF00
`define RCCR_RATE_CODE 16'hC600
// Field positions
`define RCCR_TXREG_BIT 7
`define RCCR_FIFO_BIT 6
`define RCCR_RX_BIT 7
`define RCCR_BB_BIT 6
`define RCCR_TX_BIT 5
`define RCCR_SYN_BIT 4
`define RCCR_OSC_BIT 3
`define RCCR_LBD_BIT 2
`define RCCR_WKT_BIT 1
`define RCCR_CKD_BIT 0
`define RCCR_CS_BIT 7
// Channel word limits
`define RCCR_CHAN_MIN 12'h060
`define RCCR_CHAN_MAX 12'hF3F
// Power-on ignore time in ms, and its cycle count at 100 MHz
`define RCCR_POR_MS 100
`define RCCR_CLK_MHZ 100
`define RCCR_POR_CYC (`RCCR_POR_MS * 1000 * `RCCR_CLK_MHZ)
`endif

// >>> rccr_sync.v
// Two-flop synchroniser for one pin input
`timescale 1ns/1ps
module rccr_sync (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Pin in, synchronised out
    input wire pin_in,
    output reg sync_out
);
    reg meta_q;
    // Second flop is the only reader of the first
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_out <= meta_q;
        end
    end
endmodule

// >>> rccr_shift.v
// Serial word receiver: collects 16 bits per select-low frame
`timescale 1ns/1ps
module rccr_shift (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Synchronised serial pins
    input wire sck_s,
    input wire sdi_s,
    input wire csn_s,
    // Completed word
    output reg [15:0] word_q,
    output reg word_vld_q
);
    reg sck_prev_q;
    reg [15:0] shift_q;
    reg [4:0] count_q;
    wire sck_rise = sck_s & ~sck_prev_q;
    // Shift on rising clock while selected; select high restarts
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_q <= 1'b0;
            shift_q <= 16'h0000;
            count_q <= 5'h00;
            word_q <= 16'h0000;
            word_vld_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            word_vld_q <= 1'b0;
            if (csn_s) begin
                count_q <= 5'h00;
            end else if (sck_rise) begin
                shift_q <= {shift_q[14:0], sdi_s};
                if (count_q == 5'h0F) begin
                    word_q <= {shift_q[14:0], sdi_s};
                    word_vld_q <= 1'b1;
                end
                // Later bits in the same frame are ignored until select rises
                if (count_q != 5'h10) begin
                    count_q <= count_q + 5'h01;
                end
            end
        end
    end
endmodule

// >>> rccr_top.v
// Command decoder and setting registers with derived control outputs
`timescale 1ns/1ps
`include "rccr_defs.vh"
module rccr_top #(
    parameter [31:0] POR_CYCLES = `RCCR_POR_CYC
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Serial control port
    input wire sck,
    input wire sdi,
    input wire chip_select_n,
    // Data path pins
    input wire fsk_in,
    input wire tx_reg_bit,
    input wire rx_data_in,
    input wire rx_clk_in,
    // Data path outputs
    output reg tx_bit_out,
    output reg rx_data_out,
    output reg recovered_clock_out,
    // Configuration fields
    output reg tx_data_reg_en,
    output reg rx_fifo_en,
    output reg [1:0] band_sel,
    output reg [3:0] xtal_load_sel,
    // Circuit enables
    output reg rf_front_on,
    output reg baseband_on,
    output reg pa_on,
    output reg synth_on,
    output reg xtal_osc_on,
    output reg tx_start,
    output reg low_batt_det_on,
    output reg wake_timer_on,
    output reg host_clkout_disable,
    // Synthesizer and rate settings
    output reg [11:0] channel_word,
    output reg [1:0] freq_mult,
    output reg [5:0] freq_base,
    output reg [6:0] rate_divider,
    output reg rate_prescale,
    // Ready after power-on timeout
    output reg cmd_ready
);
    // ==========================================
    // Input synchronisers
    wire sck_s;
    wire sdi_s;
    wire csn_s;
    wire fsk_s;
    wire rxd_s;
    wire rxc_s;

    // Serial clock; its edges are found only after the second flop
    rccr_sync u_sck (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in(sck),
        .sync_out(sck_s)
    );

    // Serial data; same delay as the clock keeps the bit aligned
    rccr_sync u_sdi (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in(sdi),
        .sync_out(sdi_s)
    );

    // Select; resets low, harmless while the serial clock rests low
    rccr_sync u_csn (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in(chip_select_n),
        .sync_out(csn_s)
    );

    // Transmit data pin
    rccr_sync u_fsk (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in(fsk_in),
        .sync_out(fsk_s)
    );

    // Received data pin
    rccr_sync u_rxd (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in(rx_data_in),
        .sync_out(rxd_s)
    );

    // Recovered clock pin
    rccr_sync u_rxc (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in(rx_clk_in),
        .sync_out(rxc_s)
    );

    // ==========================================
    // Serial word receiver
    // Completed word and its one-cycle strobe
    wire [15:0] word;
    wire word_vld;
    rccr_shift u_shift (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sck_s(sck_s),
        .sdi_s(sdi_s),
        .csn_s(csn_s),
        .word_q(word),
        .word_vld_q(word_vld)
    );

    // ==========================================
    // Power-on ignore window
    reg [31:0] por_cnt_q;
    reg ready_q;
    // Words arriving before the count expires are dropped
    // The count stops once ready, so it never wraps
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt_q <= 32'h00000000;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            if (por_cnt_q >= POR_CYCLES - 32'h00000001) begin
                ready_q <= 1'b1;
            end else begin
                por_cnt_q <= por_cnt_q + 32'h00000001;
            end
        end
    end

    // ==========================================
    // Command decode
    // Code match on the masked upper bits
    function hit;
        input [15:0] w;
        input [15:0] mask;
        input [15:0] code;
        begin
            hit = ((w & mask) == code);
        end
    endfunction

    reg [15:0] cfg_q;
    reg [15:0] pwr_q;
    reg [15:0] frq_q;
    reg [15:0] rate_q;
    // A word finished inside the window is lost, never queued
    wire take = word_vld & ready_q;
    // An out-of-range channel word leaves the old one in place
    wire [11:0] chan_in = word[11:0];
    wire chan_ok = (chan_in >= `RCCR_CHAN_MIN) && (chan_in <= `RCCR_CHAN_MAX);

    // Only the register whose code matches is written
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= `RCCR_CFG_RST;
            pwr_q <= `RCCR_PWR_RST;
            frq_q <= `RCCR_FRQ_RST;
            rate_q <= `RCCR_RATE_RST;
        end else if (take) begin
            if (hit(word, `RCCR_CFG_MASK, `RCCR_CFG_CODE)) begin
                cfg_q <= word;
            end
            if (hit(word, `RCCR_PWR_MASK, `RCCR_PWR_CODE)) begin
                pwr_q <= word;
            end
            if (hit(word, `RCCR_FRQ_MASK, `RCCR_FRQ_CODE) && chan_ok) begin
                frq_q <= word;
            end
            if (hit(word, `RCCR_RATE_MASK, `RCCR_RATE_CODE)) begin
                rate_q <= word;
            end
        end
    end

    // ==========================================
    // Derived enables and band constants
    // Fields that several outputs read
    wire rx_en = pwr_q[`RCCR_RX_BIT];
    wire tx_en = pwr_q[`RCCR_TX_BIT];
    wire txreg = cfg_q[`RCCR_TXREG_BIT];
    wire fifo = cfg_q[`RCCR_FIFO_BIT];
    // Power bits behind the shared enables
    wire bb_bit = pwr_q[`RCCR_BB_BIT];
    wire syn_bit = pwr_q[`RCCR_SYN_BIT];
    wire osc_bit = pwr_q[`RCCR_OSC_BIT];
    reg [1:0] mult_d;
    reg [5:0] base_d;
    // Band constants feed the synthesizer: f = 10*C1*(C2 + F/4000) MHz
    // C1 sits in the multiplier, C2 in the base
    always @* begin
        case (cfg_q[5:4])
            2'b00: begin
                mult_d = 2'h1;
                base_d = 6'h1F;
            end
            2'b01: begin
                mult_d = 2'h1;
                base_d = 6'h2B;
            end
            2'b10: begin
                mult_d = 2'h2;
                base_d = 6'h2B;
            end
            default: begin
                mult_d = 2'h3;
                base_d = 6'h1E;
            end
        endcase
    end

    // ==========================================
    // Registered outputs
    // Data path: pins add one cycle past the synchronisers
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_bit_out <= 1'b0;
            rx_data_out <= 1'b0;
            recovered_clock_out <= 1'b0;
        end else begin
            // Internal register path relies on the host tying fsk high
            tx_bit_out <= txreg ? (tx_reg_bit & fsk_s) : fsk_s;
            // With FIFO on, the pins rest low instead of carrying data
            rx_data_out <= fifo ? 1'b0 : rxd_s;
            recovered_clock_out <= fifo ? 1'b0 : rxc_s;
        end
    end

    // Configuration fields; code bits 15 to 8 are not brought out
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_reg_en <= 1'b0;
            rx_fifo_en <= 1'b0;
            band_sel <= 2'b00;
            xtal_load_sel <= 4'h0;
        end else begin
            tx_data_reg_en <= txreg;
            rx_fifo_en <= fifo;
            band_sel <= cfg_q[5:4];
            xtal_load_sel <= cfg_q[3:0];
        end
    end

    // Circuit enables; receive and transmit pull in what they depend on
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rf_front_on <= 1'b0;
            baseband_on <= 1'b0;
            pa_on <= 1'b0;
            synth_on <= 1'b0;
            xtal_osc_on <= 1'b0;
            tx_start <= 1'b0;
            low_batt_det_on <= 1'b0;
            wake_timer_on <= 1'b0;
            host_clkout_disable <= 1'b0;
        end else begin
            rf_front_on <= rx_en;
            baseband_on <= rx_en | bb_bit;
            pa_on <= tx_en;
            // Separate bits keep circuits running between modes
            synth_on <= rx_en | tx_en | syn_bit;
            xtal_osc_on <= rx_en | tx_en | syn_bit | osc_bit;
            tx_start <= tx_en & txreg;
            low_batt_det_on <= pwr_q[`RCCR_LBD_BIT];
            wake_timer_on <= pwr_q[`RCCR_WKT_BIT];
            host_clkout_disable <= pwr_q[`RCCR_CKD_BIT];
        end
    end

    // Synthesizer and rate settings
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_word <= 12'h000;
            freq_mult <= 2'h0;
            freq_base <= 6'h00;
            rate_divider <= 7'h00;
            rate_prescale <= 1'b0;
        end else begin
            channel_word <= frq_q[11:0];
            freq_mult <= mult_d;
            freq_base <= base_d;
            rate_divider <= rate_q[6:0];
            rate_prescale <= rate_q[`RCCR_CS_BIT];
        end
    end

    // Ready flag trails the internal window flag by one cycle
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ready <= 1'b0;
        end else begin
            cmd_ready <= ready_q;
        end
    end
endmodule

// >>> rccr_top_assertions.sv
// Concurrent checks on the command register block ports
`timescale 1ns/1ps
module rccr_top_assertions (
    // Clock and reset
    input logic ref_clk,
    input logic rst_n,
    // Select and ready
    input logic chip_select_n,
    input logic cmd_ready,
    // Watched outputs
    input logic rx_data_out,
    input logic recovered_clock_out,
    input logic tx_data_reg_en,
    input logic rx_fifo_en,
    input logic [1:0] band_sel,
    input logic rf_front_on,
    input logic baseband_on,
    input logic pa_on,
    input logic synth_on,
    input logic xtal_osc_on,
    input logic tx_start,
    input logic [11:0] channel_word,
    input logic [1:0] freq_mult,
    input logic [5:0] freq_base,
    input logic [6:0] rate_divider
);
    // ====
    // Helpers: guards skip the edges right after reset release
    logic [1:0] up_q;
    logic [3:0] idle_q;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 2'h0;
            idle_q <= 4'h0;
        end else begin
            up_q <= up_q + {1'b0, up_q != 2'h3};
            idle_q <= !chip_select_n ? 4'h0 : idle_q + {3'h0, idle_q != 4'hF};
        end
    end
    wire live = up_q == 2'h3;
    wire [25:0] set_v = {tx_data_reg_en, rx_fifo_en, band_sel, rf_front_on, pa_on, synth_on,
        channel_word, rate_divider};
    // ====
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_quiet;
        live && idle_q == 4'hF;
    endsequence
    sequence s_fifo_held;
        rx_fifo_en [*4];
    endsequence
    sequence s_pins_low;
        !rx_data_out && !recovered_clock_out;
    endsequence
    AST_RX_CHAIN: assert property (rf_front_on |-> baseband_on && synth_on && xtal_osc_on)
        else $error("rx chain enable incomplete");
    AST_TX_POWER: assert property (pa_on |-> synth_on && xtal_osc_on)
        else $error("tx enable without synth or osc");
    AST_TX_START: assert property (live |-> tx_start == (pa_on && tx_data_reg_en))
        else $error("tx start mismatch");
    AST_SYN_OSC: assert property (synth_on |-> xtal_osc_on)
        else $error("synth on without osc");
    AST_CHAN_RANGE: assert property (live |-> channel_word inside {[12'h060:12'hF3F]})
        else $error("channel word out of range");
    AST_BAND_CONST: assert property (live |-> {freq_mult, freq_base} == (band_sel == 2'h0 ?
        8'h5F : band_sel == 2'h1 ? 8'h6B : band_sel == 2'h2 ? 8'hAB : 8'hDE))
        else $error("band constants mismatch");
    AST_FIFO_QUIET: assert property (live ##0 s_fifo_held |-> s_pins_low)
        else $error("data pins active with fifo");
    AST_POR_HOLD: assert property (live && !cmd_ready |=> $stable(set_v))
        else $error("setting changed before ready");
    AST_IDLE_HOLD: assert property (s_quiet |=> $stable(set_v))
        else $error("setting changed outside frame");
endmodule
bind rccr_top rccr_top_assertions u_chk (.ref_clk, .rst_n, .chip_select_n, .cmd_ready,
    .rx_data_out, .recovered_clock_out, .tx_data_reg_en, .rx_fifo_en, .band_sel, .rf_front_on,
    .baseband_on, .pa_on, .synth_on, .xtal_osc_on, .tx_start, .channel_word, .freq_mult,
    .freq_base, .rate_divider);

// >>> rccr_host_model.sv
// Host model sending control words over the serial port
`timescale 1ns/1ps
module rccr_host_model (
    // Bench clock for launch alignment
    input wire logic ref_clk,
    // Serial pins
    output logic sck,
    output logic sdi,
    output logic chip_select_n
);
    // Idle: clock parked low, select high
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        chip_select_n = 1'b1;
    end
    // One frame, MSB first; bits past 16 are random filler
    task automatic frame(input logic [15:0] w, input int nbits);
        @(negedge ref_clk);
        chip_select_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi = (i < 16) ? w[15 - i] : 1'($urandom);
            #80 sck = 1'b1;
            #80 sck = 1'b0;
        end
        #80 chip_select_n = 1'b1;
        sdi = ~sdi; // Released line shows no stale bit
        #80;
    endtask
endmodule

// >>> tb_radio_config_command_regs.sv
// Self-checking bench for the command register block
`timescale 1ns/1ps
module tb_radio_config_command_regs;
    // ====
    // Signals and model state
    logic ref_clk = 1'b0, rst_n = 1'b0, fsk_in = 1'b0, tx_reg_bit = 1'b0;
    logic rx_data_in = 1'b0, rx_clk_in = 1'b0;
    wire sck, sdi, chip_select_n, tx_bit_out, rx_data_out, recovered_clock_out, cmd_ready;
    wire tx_data_reg_en, rx_fifo_en, rf_front_on, baseband_on, pa_on, synth_on, xtal_osc_on;
    wire tx_start, low_batt_det_on, wake_timer_on, host_clkout_disable, rate_prescale;
    wire [1:0] band_sel, freq_mult;
    wire [3:0] xtal_load_sel;
    wire [5:0] freq_base;
    wire [6:0] rate_divider;
    wire [11:0] channel_word;
    logic [15:0] cfg, pwr, frq, rate, w;
    logic rdy = 1'b0;
    logic [11:0] lim [4] = '{12'h05F, 12'h060, 12'hF3F, 12'hF40};
    logic [48:0] exp_q [$];
    int bad_count = 0, samples_checked = 0, n;
    event chk_ev;
    wire [48:0] got_v = {cmd_ready, tx_data_reg_en, rx_fifo_en, band_sel, xtal_load_sel,
        rf_front_on, baseband_on, pa_on, synth_on, xtal_osc_on, tx_start, low_batt_det_on,
        wake_timer_on, host_clkout_disable, channel_word, freq_mult, freq_base, rate_divider,
        rate_prescale, tx_bit_out, rx_data_out, recovered_clock_out};
    // Short power-on window keeps the run brief
    rccr_top #(.POR_CYCLES(32'd400)) DUT (.ref_clk, .rst_n, .sck, .sdi, .chip_select_n,
        .fsk_in, .tx_reg_bit, .rx_data_in, .rx_clk_in, .tx_bit_out, .rx_data_out,
        .recovered_clock_out, .tx_data_reg_en, .rx_fifo_en, .band_sel, .xtal_load_sel,
        .rf_front_on, .baseband_on, .pa_on, .synth_on, .xtal_osc_on, .tx_start,
        .low_batt_det_on, .wake_timer_on, .host_clkout_disable, .channel_word, .freq_mult,
        .freq_base, .rate_divider, .rate_prescale, .cmd_ready);
    rccr_host_model host (.ref_clk, .sck, .sdi, .chip_select_n);
    // Clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // ====
    // Tasks
    task automatic check(input logic [48:0] seen, input logic [48:0] expd);
        samples_checked++;
        if (seen !== expd) begin
            bad_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [48:0] expect_v();
        logic [7:0] b;
        b = cfg[5] ? (cfg[4] ? 8'hDE : 8'hAB) : (cfg[4] ? 8'h6B : 8'h5F);
        return {rdy, cfg[7:0], pwr[7], pwr[7] | pwr[6], pwr[5], pwr[7] | pwr[5] | pwr[4],
            pwr[7] | pwr[5] | pwr[4] | pwr[3], pwr[5] & cfg[7], pwr[2:0], frq[11:0], b,
            rate[6:0], rate[7], cfg[7] ? tx_reg_bit & fsk_in : fsk_in,
            ~cfg[6] & rx_data_in, ~cfg[6] & rx_clk_in};
    endfunction
    // Model update for one accepted word
    task automatic apply();
        if (w[15:8] == 8'h80) cfg = w;
        else if (w[15:8] == 8'h82) pwr = w;
        else if (w[15:12] == 4'hA && w[11:0] >= 12'h060 && w[11:0] <= 12'hF3F) frq = w;
        else if (w[15:8] == 8'hC6) rate = w;
    endtask
    // Drive data pins, let them settle, then note the expectation
    task automatic pins(input logic [3:0] v);
        @(negedge ref_clk);
        fsk_in = cfg[7] ? 1'b1 : v[3];
        tx_reg_bit = v[2];
        rx_data_in = v[1];
        rx_clk_in = v[0];
        repeat (8) @(negedge ref_clk);
        exp_q.push_back(expect_v());
        -> chk_ev;
    endtask
    // Result watcher takes the oldest note
    always @(chk_ev) begin
        check(got_v, exp_q.pop_front());
    end
    // ====
    // Main sequence
    initial begin
        void'($urandom(32'h2E17));
        cfg = 16'h8008;
        pwr = 16'h8208;
        frq = 16'hA680;
        rate = 16'hC623;
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
        pins(4'h3);
        host.frame(16'h8207, 16);
        pins(4'hC);
        n = 0;
        while (cmd_ready !== 1'b1 && n < 1000) begin
            @(negedge ref_clk);
            n++;
        end
        // A window that never closes counts as a mismatch
        if (cmd_ready !== 1'b1) bad_count++;
        rdy = 1'b1;
        w = 16'h80F5;
        host.frame(w, 10);
        pins(4'h5);
        host.frame(w, 20);
        apply();
        pins(4'hA);
        for (int i = 0; i < 40; i++) begin
            w = 16'($urandom);
            case (i % 8)
                0: w = {8'h80, w[7:6], 2'(i / 8), w[3:0]};
                1: w[15:8] = 8'h82;
                2: w[15:12] = 4'hA;
                3: w[15:8] = 8'hC6;
                4: w = {4'hA, lim[i / 8 % 4]};
                5: w[15:8] = 8'h81;
                default: ;
            endcase
            host.frame(w, 16);
            apply();
            pins(4'($urandom));
        end
        final_report();
    end
    // Watchdog
    initial begin
        #400000;
        bad_count++;
        final_report();
    end
endmodule
